// ==== verilog/module_power_key_reset_control.sv ====
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - off: key low 100ms-2s then release powers on
// - on: key low 3s-8s then release shuts down
// - on: reset low 700ms-1s then release resets
// - host waits 30ms after stable supply
// - after software off, low key powers on
// - supply loss powers off, no deregistration
// - host only pulls key low, open drain
// - host shuts down before removing supply; the testbench cuts supply while powered on, with no CMD_OFF first
module module_power_key_reset_control
   import pwr_seq_pkg::*;
#(
   // clock cycles per millisecond, lowered only to shorten simulation
   parameter int CYC_MS = CYC_PER_MS
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // link
   pwr_key_if.dev LINK,
   // supply and software
   input wire logic SUPPLY_OK,
   input wire logic SW_OFF,
   // status
   output logic POWERED,
   output logic RESET_PULSE,
   output logic DEREG_PULSE
);
   typedef enum logic [1:0] {
      ST_OFF,
      ST_ON,
      ST_SW_OFF
   } dstate_t;

   typedef struct packed {
      dstate_t st;
      logic [PRE_W-1:0] pre;
      logic [MS_W-1:0] key_ms;
      logic [MS_W-1:0] rst_ms;
      logic key_q;
      logic rst_q;
      logic powered;
      logic reset_pulse;
      logic dereg_pulse;
   } dev_t;

   dev_t s_r;
   dev_t s_nxt;
   logic tick;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_nxt = s_r;
      s_nxt.reset_pulse = 1'b0;
      s_nxt.dereg_pulse = 1'b0;
      tick = (s_r.pre == PRE_W'(CYC_MS - 1));
      s_nxt.pre = tick ? PRE_ZERO : s_r.pre + PRE_ONE;
      s_nxt.key_q = LINK.power_key_n;
      s_nxt.rst_q = LINK.hard_reset_n;
      // millisecond low-time counters, saturating
      if (!s_r.key_q) begin
         if (tick && s_r.key_ms != MS_MAX) begin
            s_nxt.key_ms = s_r.key_ms + MS_ONE;
         end
      end else begin
         s_nxt.key_ms = MS_ZERO;
      end
      if (!s_r.rst_q) begin
         if (tick && s_r.rst_ms != MS_MAX) begin
            s_nxt.rst_ms = s_r.rst_ms + MS_ONE;
         end
      end else begin
         s_nxt.rst_ms = MS_ZERO;
      end
      case (s_r.st)
         ST_OFF: begin
            if (SUPPLY_OK && s_r.key_q == 1'b0 && LINK.power_key_n
                && s_r.key_ms >= MS_W'(ON_MIN_MS)
                && s_r.key_ms <= MS_W'(ON_MAX_MS)) begin
               s_nxt.st = ST_ON;
            end
         end
         ST_ON: begin
            if (SW_OFF) begin
               s_nxt.st = ST_SW_OFF;
               s_nxt.dereg_pulse = 1'b1;
            end else if (s_r.key_q == 1'b0 && LINK.power_key_n
                && s_r.key_ms >= MS_W'(OFF_MIN_MS)
                && s_r.key_ms <= MS_W'(OFF_MAX_MS)) begin
               s_nxt.st = ST_OFF;
               s_nxt.dereg_pulse = 1'b1;
            end else if (s_r.rst_q == 1'b0 && LINK.hard_reset_n
                && s_r.rst_ms >= MS_W'(RST_MIN_MS)
                && s_r.rst_ms <= MS_W'(RST_MAX_MS)) begin
               s_nxt.reset_pulse = 1'b1;
            end
         end
         ST_SW_OFF: begin
            // a low key here restarts the module at once
            if (!s_r.key_q) begin
               s_nxt.st = ST_ON;
            end
         end
         default: begin
            s_nxt.st = ST_OFF;
         end
      endcase
      // loss of supply wins over everything, no deregistration
      if (!SUPPLY_OK) begin
         s_nxt.st = ST_OFF;
         s_nxt.dereg_pulse = 1'b0;
         s_nxt.reset_pulse = 1'b0;
      end
      s_nxt.powered = (s_nxt.st == ST_ON);
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         s_r <= '{st: ST_OFF, pre: PRE_ZERO, key_ms: MS_ZERO,
                  rst_ms: MS_ZERO, key_q: 1'b1, rst_q: 1'b1,
                  powered: 1'b0, reset_pulse: 1'b0, dereg_pulse: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign POWERED = s_r.powered;
   assign RESET_PULSE = s_r.reset_pulse;
   assign DEREG_PULSE = s_r.dereg_pulse;
endmodule : module_power_key_reset_control
`default_nettype wire

// ==== verilog/pwr_seq_pkg.sv ====
package pwr_seq_pkg;
   // ****************************************
   // clock and timing
   // ****************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int ON_MIN_MS = 100;
   localparam int ON_MAX_MS = 2000;
   localparam int OFF_MIN_MS = 3000;
   localparam int OFF_MAX_MS = 8000;
   localparam int RST_MIN_MS = 700;
   localparam int RST_MAX_MS = 1000;
   localparam int SUPPLY_WAIT_MS = 30;
   // host targets, inside each window, centred only for reset
   localparam int ON_HOLD_MS = 500;
   localparam int OFF_HOLD_MS = 5000;
   localparam int RST_HOLD_MS = 850;
   localparam int MS_W = 16;
   localparam logic [MS_W-1:0] MS_ZERO = 16'h0000;
   localparam logic [MS_W-1:0] MS_ONE = 16'h0001;
   localparam logic [MS_W-1:0] MS_MAX = 16'hFFFF;
   localparam int PRE_W = 16;
   localparam logic [PRE_W-1:0] PRE_ZERO = 16'h0000;
   localparam logic [PRE_W-1:0] PRE_ONE = 16'h0001;

   // ****************************************
   // host commands
   // ****************************************
   typedef enum logic [1:0] {
      CMD_ON,
      CMD_OFF,
      CMD_RESET
   } cmd_t;
endpackage : pwr_seq_pkg

// ==== verilog/pwr_key_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface pwr_key_if;
   // open-drain lines, wire level resolved by the testbench
   logic power_key_n_o;
   logic power_key_n_oe;
   logic power_key_n;
   logic hard_reset_n_o;
   logic hard_reset_n_oe;
   logic hard_reset_n;
   modport host (
      output power_key_n_o, power_key_n_oe,
      output hard_reset_n_o, hard_reset_n_oe,
      input power_key_n, hard_reset_n
   );
   modport dev (
      input power_key_n, hard_reset_n
   );
endinterface : pwr_key_if
`default_nettype wire

// ==== verilog/power_key_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module power_key_host
   import pwr_seq_pkg::*;
#(
   // clock cycles per millisecond, lowered only to shorten simulation
   parameter int CYC_MS = CYC_PER_MS
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // link
   pwr_key_if.host LINK,
   // user side
   input wire logic SUPPLY_STABLE,
   input wire logic CMD_VALID,
   input wire cmd_t CMD,
   output logic CMD_READY,
   output logic BUSY
);
   typedef enum logic [1:0] {
      H_WAIT,
      H_IDLE,
      H_PULSE
   } hstate_t;

   typedef struct packed {
      hstate_t st;
      logic [PRE_W-1:0] pre;
      logic [MS_W-1:0] ms;
      logic [MS_W-1:0] target;
      logic key_low;
      logic rst_low;
   } host_t;

   host_t s_r;
   host_t s_nxt;
   logic tick;

   always_comb begin
      s_nxt = s_r;
      tick = (s_r.pre == PRE_W'(CYC_MS - 1));
      s_nxt.pre = tick ? PRE_ZERO : s_r.pre + PRE_ONE;
      if (tick) begin
         s_nxt.ms = s_r.ms + MS_ONE;
      end
      case (s_r.st)
         H_WAIT: begin
            // counting from supply stable before touching the key
            if (!SUPPLY_STABLE) begin
               s_nxt.ms = MS_ZERO;
            end else if (s_r.ms >= MS_W'(SUPPLY_WAIT_MS)) begin
               s_nxt.st = H_IDLE;
            end
         end
         H_IDLE: begin
            if (!SUPPLY_STABLE) begin
               s_nxt.st = H_WAIT;
               s_nxt.ms = MS_ZERO;
            end else if (CMD_VALID) begin
               s_nxt.st = H_PULSE;
               s_nxt.ms = MS_ZERO;
               s_nxt.pre = PRE_ZERO;
               // fixed lengths, never in the undefined gap
               case (CMD)
                  CMD_ON: begin
                     s_nxt.target = MS_W'(ON_HOLD_MS);
                     s_nxt.key_low = 1'b1;
                  end
                  CMD_OFF: begin
                     s_nxt.target = MS_W'(OFF_HOLD_MS);
                     s_nxt.key_low = 1'b1;
                  end
                  CMD_RESET: begin
                     s_nxt.target = MS_W'(RST_HOLD_MS);
                     s_nxt.rst_low = 1'b1;
                  end
                  default: begin
                     s_nxt.st = H_IDLE;
                  end
               endcase
            end
         end
         H_PULSE: begin
            if (s_r.ms >= s_r.target) begin
               s_nxt.st = H_IDLE;
               s_nxt.key_low = 1'b0;
               s_nxt.rst_low = 1'b0;
            end
         end
         default: begin
            s_nxt.st = H_WAIT;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         s_r <= '{st: H_WAIT, pre: PRE_ZERO, ms: MS_ZERO,
                  target: MS_ZERO, key_low: 1'b0, rst_low: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // open drain: only ever pull low, released means not driven
   assign LINK.power_key_n_o = 1'b0;
   assign LINK.power_key_n_oe = s_r.key_low;
   assign LINK.hard_reset_n_o = 1'b0;
   assign LINK.hard_reset_n_oe = s_r.rst_low;
   assign CMD_READY = (s_r.st == H_IDLE) && SUPPLY_STABLE;
   assign BUSY = (s_r.st != H_IDLE);
endmodule : power_key_host
`default_nettype wire

// ==== sim/pwr_key_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// link checker
// ****************************************
module pwr_key_props
   import pwr_seq_pkg::*;
#(
   parameter int CYC_MS = CYC_PER_MS
)
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // link
   input wire logic power_key_n_o,
   input wire logic power_key_n_oe,
   input wire logic hard_reset_n_o,
   input wire logic hard_reset_n_oe
);
   localparam int MS = CYC_MS;
   int unsigned key_r, rst_r, up_r;
   always_ff @(posedge CLK_SYS) begin
      key_r <= (SRST || !power_key_n_oe) ? 0 : key_r + 1;
      rst_r <= (SRST || !hard_reset_n_oe) ? 0 : rst_r + 1;
      up_r <= SRST ? 0 : (up_r < SUPPLY_WAIT_MS * MS ? up_r + 1 : up_r);
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   a_key_pull_only: assert property (power_key_n_o == 1'b0)
      else $error("key driven high");
   a_rst_pull_only: assert property (hard_reset_n_o == 1'b0)
      else $error("reset driven high");
   a_key_len_ok: assert property ($fell(power_key_n_oe) |->
      (key_r >= ON_MIN_MS * MS && key_r < (ON_MAX_MS + 1) * MS) ||
      (key_r >= OFF_MIN_MS * MS && key_r < (OFF_MAX_MS + 1) * MS))
      else $error("key pulse length");
   a_rst_len_ok: assert property ($fell(hard_reset_n_oe) |->
      rst_r >= RST_MIN_MS * MS && rst_r < (RST_MAX_MS + 1) * MS)
      else $error("reset pulse length");
   a_no_early_key: assert property (up_r < SUPPLY_WAIT_MS * MS
      |-> !power_key_n_oe && !hard_reset_n_oe)
      else $error("line pulled too early");
   a_key_hold_min: assert property ($rose(power_key_n_oe)
      |=> power_key_n_oe [*8])
      else $error("key glitch");
   a_rst_hold_min: assert property ($rose(hard_reset_n_oe)
      |=> hard_reset_n_oe [*8])
      else $error("reset glitch");
   a_key_stays_up: assert property (power_key_n_oe &&
      key_r < ON_MIN_MS * MS |=> power_key_n_oe)
      else $error("key short");
   c_key: cover property ($fell(power_key_n_oe));
   c_rst: cover property ($fell(hard_reset_n_oe));
   c_long: cover property ($fell(power_key_n_oe) && key_r > OFF_MIN_MS * MS);
endmodule // pwr_key_props
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench
   import pwr_seq_pkg::*;
;
   // ****************************************
   // clock, link and design
   // ****************************************
   logic clk = 1'b0, srst = 1'b1, sup = 1'b0, sw_off = 1'b0;
   logic cmd_valid = 1'b0, cmd_ready, busy, powered, rst_p, dereg_p;
   cmd_t cmd = CMD_ON;
   int n_fail = 0, tests_run = 0, n_rp = 0, n_dr = 0, e_rp = 0, e_dr = 0;
   longint cyc = 0;
   // real ms would need millions of cycles per test, so scale it down
   localparam int TB_MS = 8;
   pwr_key_if link ();
   assign link.power_key_n = link.power_key_n_oe ? 1'b0 : 1'b1;
   assign link.hard_reset_n = link.hard_reset_n_oe ? 1'b0 : 1'b1;
   power_key_host #(.CYC_MS(TB_MS)) power_key_host_inst (
      .CLK_SYS(clk), .SRST(srst),
      .LINK(link), .SUPPLY_STABLE(sup), .CMD_VALID(cmd_valid), .CMD(cmd),
      .CMD_READY(cmd_ready), .BUSY(busy));
   module_power_key_reset_control #(.CYC_MS(TB_MS))
      module_power_key_reset_control_inst (
      .CLK_SYS(clk), .SRST(srst), .LINK(link), .SUPPLY_OK(sup),
      .SW_OFF(sw_off), .POWERED(powered), .RESET_PULSE(rst_p),
      .DEREG_PULSE(dereg_p));
   pwr_key_props #(.CYC_MS(TB_MS)) pwr_key_props_inst (
      .CLK_SYS(clk), .SRST(srst),
      .power_key_n_o(link.power_key_n_o),
      .power_key_n_oe(link.power_key_n_oe),
      .hard_reset_n_o(link.hard_reset_n_o),
      .hard_reset_n_oe(link.hard_reset_n_oe));
   initial forever #12.5 clk = ~clk;
   // pulses are one cycle wide, so count them every edge
   // sampled at the falling edge, where registered outputs are settled
   always @(negedge clk) begin
      cyc++;
      if (rst_p === 1'b1) n_rp++;
      if (dereg_p === 1'b1) n_dr++;
      if (cyc == 64'd90_000) begin
         n_fail++;
         final_report();
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   task automatic chk_all(input logic pw);
      @(negedge clk);
      chk(powered, pw);
      chk(logic'(n_rp == e_rp), 1'b1);
      chk(logic'(n_dr == e_dr), 1'b1);
   endtask
   task automatic run_cmd(input cmd_t c);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= c;
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do @(posedge clk); while (busy !== 1'b0);
      repeat (4) @(posedge clk);
      $display("test %s done at %0t", c.name(), $time);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      void'($urandom(99449));
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      sup <= 1'b1;
      run_cmd(CMD_ON);
      chk_all(1'b1);
      run_cmd(CMD_RESET);
      e_rp++;
      chk_all(1'b1);
      repeat ($urandom % 50 + 2) @(posedge clk);
      sw_off <= 1'b1;
      @(posedge clk);
      sw_off <= 1'b0;
      repeat (4) @(posedge clk);
      e_dr++;
      chk_all(1'b0);
      run_cmd(CMD_ON);
      chk_all(1'b1);
      run_cmd(CMD_OFF);
      e_dr++;
      chk_all(1'b0);
      run_cmd(CMD_ON);
      repeat ($urandom % 50 + 2) @(posedge clk);
      sup <= 1'b0;
      repeat (4) @(posedge clk);
      chk_all(1'b0);
      final_report();
   end
endmodule // testbench
`default_nettype wire
